// ### hdl/pbo_pkg.sv
/*
  Shared constants, types and helpers for the packet buffer ownership engine.
  Assumes 16-bit host words and an 18-bit byte address into host memory.
*/
package pbo_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  ////////////////////////////////////////////////////////////////////////////
  // Register window
  localparam logic [1:0] REG_CMD_PTR = 2'h0;
  localparam logic [1:0] REG_STATUS  = 2'h2;
  // Status register fields
  localparam int ST_FAIL = 15;
  localparam int ST_RMR  = 12;
  localparam int ST_REJ  = 11;
  localparam int ST_SSR  = 7;
  localparam int ST_IE   = 5;
  localparam int ST_VCK  = 4;
  localparam logic ST_VCK_RESET = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // Command header fields
  localparam int HDR_ACK = 15;
  localparam int HDR_CVC = 14;
  localparam int FMT_HI  = 7;
  localparam int FMT_LO  = 5;
  localparam int LEN_HI  = 4;
  localparam int LEN_LO  = 3;
  localparam int CODE_HI = 4;
  localparam int CODE_LO = 0;
  localparam logic [2:0] FMT_IRQ_ON  = 3'h4;
  localparam logic [2:0] FMT_IRQ_OFF = 3'h0;
  localparam logic [1:0] LEN_FOUR    = 2'h0;
  localparam logic [1:0] PARMS_LONG  = 2'h3;
  localparam logic [1:0] PARMS_SHORT = 2'h1;
  localparam logic [4:0] CODE_READ    = 5'h01;
  localparam logic [4:0] CODE_SETCHAR = 5'h04;
  localparam logic [4:0] CODE_WRITE   = 5'h05;
  localparam logic [4:0] CODE_POS     = 5'h08;
  localparam logic [4:0] CODE_FORMAT  = 5'h09;
  localparam logic [4:0] CODE_XINIT   = 5'h0B;
  localparam logic [4:0] CODE_RELEASE = 5'h0E;
  localparam logic [4:0] CODE_GETSTAT = 5'h0F;
  ////////////////////////////////////////////////////////////////////////////
  // Message header word
  localparam int MSG_ACK = 15;
  localparam logic [3:0] MSG_END  = 4'h0;
  localparam logic [3:0] MSG_UNSOLICITED_ALERT = 4'h1;
  localparam logic [3:0] MSG_FAIL = 4'h2;
  localparam logic [3:0] MSG_REJ  = 4'h3;
  localparam logic [ADDR_W-1:0] WORD_STEP = 18'h00002;
  localparam logic [1:0] PIDX_ZERO = 2'h0;
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pbo_mreq_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_HDR, ST_PARM, ST_DECIDE, ST_EXEC, ST_MSG0, ST_MSG1, ST_FINISH
  } pbo_state_t;

  function automatic logic [DATA_W-1:0] status_image(
    input logic subsystem_ready_flag, input logic register_write_refused, input logic vck, input logic ie,
    input logic fail, input logic rej);
    logic [DATA_W-1:0] v;
    v = '0;
    v[ST_SSR]  = subsystem_ready_flag;
    v[ST_RMR]  = register_write_refused;
    v[ST_VCK]  = vck;
    v[ST_IE]   = ie;
    v[ST_FAIL] = fail;
    v[ST_REJ]  = rej;
    return v;
  endfunction

  function automatic logic legal_code(input logic [4:0] c);
    return c == CODE_READ || c == CODE_SETCHAR || c == CODE_WRITE ||
           c == CODE_POS || c == CODE_FORMAT || c == CODE_XINIT ||
           c == CODE_RELEASE || c == CODE_GETSTAT;
  endfunction
endpackage

// ### hdl/pbo_dma.sv
/*
  Single-word host memory mover: one read or write per go pulse.
  Assumes memory answers each held request with a one-cycle grant.
*/
`timescale 1ns/1ns
module pbo_dma import pbo_pkg::*; (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              resetn,
  // Engine side
  input  wire logic              go,
  input  wire pbo_mreq_t         req,
  output logic                   done_q,
  output logic                   err_q,
  output logic [DATA_W-1:0]      rdata_q,
  // Memory side
  output logic                   mem_req_q,
  output pbo_mreq_t              mem_q,
  input  wire logic              mem_gnt,
  input  wire logic              mem_err,
  input  wire logic [DATA_W-1:0] mem_rdata
);
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mem_req_q <= 1'b0;
      mem_q     <= '0;
      done_q    <= 1'b0;
      err_q     <= 1'b0;
      rdata_q   <= '0;
    end else begin
      done_q <= 1'b0;
      if (go && !mem_req_q) begin
        mem_req_q <= 1'b1;
        mem_q     <= req;
      end else if (mem_req_q && mem_gnt) begin
        mem_req_q <= 1'b0;
        done_q    <= 1'b1;
        err_q     <= mem_err;
        rdata_q   <= mem_rdata;
      end
    end
  end

  held_req_a: assert property (@(posedge clock) disable iff (!resetn)
    mem_req_q && !mem_gnt |=> mem_req_q && $stable(mem_q))
    else $error("memory request dropped before grant");
endmodule // pbo_dma

// ### hdl/pbo_irq.sv
/*
  Interrupt pulse on each rise of subsystem ready while interrupts are permitted.
  Assumes ready and permit are registered in the same clock domain.
*/
`timescale 1ns/1ns
module pbo_irq import pbo_pkg::*; (
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Status in
  input  wire logic ready,
  input  wire logic permit,
  // Interrupt out
  output logic      irq_q
);
  logic ready_q;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ready_q <= 1'b1;
      irq_q   <= 1'b0;
    end else begin
      ready_q <= ready;
      irq_q   <= ready && !ready_q && permit; // RL24
    end
  end

  irq_cause_a: assert property (@(posedge clock) disable iff (!resetn) // RL24
    irq_q |-> $past(permit) && $past(ready) && !$past(ready, 2))
    else $error("interrupt without ready rise under permit");
  irq_single_a: assert property (@(posedge clock) disable iff (!resetn) // RL24
    irq_q |=> !irq_q)
    else $error("interrupt longer than one cycle");
endmodule // pbo_irq

// ### hdl/pbo_engine.sv
/*
  Packet engine: command pointer and status registers, packet fetch, message
  return and buffer ownership between host and device.
  Assumes a tape transport that takes a start pulse and answers with done,
  and a host memory that grants one word request at a time.
*/
// Chosen here: the register addresses and the plain strobed port.
// Notes on behaviour
// RL1: Host passes each command packet location by writing the command pointer.
// RL2: Set-characteristics command supplies the message buffer location for later messages.
// RL3: Each buffer has exactly one owner; only its owner hands it over.
// RL4: Pointer write gives command buffer to device and clears subsystem ready.
// RL5: Device returns command buffer with acknowledged message, then sets ready.
// RL6: Message without acknowledge means host still owns command buffer.
// RL7: Command without acknowledge: no message, only ready set and interrupt.
// RL8: Command completion sets ready and interrupts when permitted.
// RL9: Alert only when idle: clear ready, write message, set ready again.
// RL10: Pointer write while ready clear sets refused bit; command ignored.
// RL11: Alert messages always carry a clear acknowledge bit.
// RL12: Lost command keeps volume and permit bits; rejected command updates them.
// RL13: Initialization updates status; host owns both buffers.
// RL14: First host command must be acknowledged set-characteristics.
// RL15: Alert waits for next acknowledged command, then refuses that command.
// RL16: Release command: no message, ready set, device keeps message buffer.
// RL17: No second alert until host acknowledges the buffer holding the first.
// RL18: After release, host acknowledge bit has no effect.
// RL19: Memory or parity error during packet fetch always sends failure message.
// RL20: Host tolerates a nested interrupt after fatal device errors.
// RL21: Header bit 15 is acknowledge, handing message buffer to device.
// RL22: Header format 100 permits completion interrupt, 000 forbids it.
// RL23: Code bits 04:03 give four-word or two-word packet length.
// RL24: At most one interrupt per ready rise, only while permitted.
`timescale 1ns/1ns
module pbo_engine import pbo_pkg::*; (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              resetn,
  // Register port
  input  wire logic [1:0]        reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [DATA_W-1:0]      reg_rdata_q,
  // Host memory
  output logic                   mem_req,
  output pbo_mreq_t              mem_out,
  input  wire logic              mem_gnt,
  input  wire logic              mem_err,
  input  wire logic [DATA_W-1:0] mem_rdata,
  // Transport
  input  wire logic              unsolicited_alert,
  input  wire logic              volume_change_in,
  output logic                   xport_start_q,
  output logic [DATA_W-1:0]      xport_hdr_q,
  output logic [DATA_W-1:0]      xport_parm_q,
  input  wire logic              xport_done,
  // Interrupt
  output logic                   irq
);
  pbo_state_t        st_q;
  logic              subsystem_ready_flag_q;
  logic              msg_own_q;
  logic              keep_q;
  logic              alert_pend_q;
  logic              issued_q;
  logic              dma_go_q;
  logic [3:0]        kind_q;
  logic              mack_q;
  logic [ADDR_W-1:0] command_pointer_register_q;
  logic [ADDR_W-1:0] faddr_q;
  logic [ADDR_W-1:0] msg_addr_q;
  logic [DATA_W-1:0] hdr_q;
  logic [DATA_W-1:0] p0_q;
  logic [DATA_W-1:0] p1_q;
  logic [1:0]        left_q;
  logic [1:0]        pidx_q;
  logic              register_write_refused_q;
  logic              volume_change_flag_q;
  logic              interrupt_permit_latch_q;
  logic              fail_q;
  logic              rej_q;
  logic              dma_done;
  logic              dma_err;
  logic [DATA_W-1:0] dma_rdata;
  pbo_mreq_t         dreq;
  logic              cmd_wr;
  logic              accept;
  logic              own_now;
  logic              alert_go;
  logic              upd_ctl;
  logic              dma_state;
  logic [4:0]        code;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  assign code      = hdr_q[CODE_HI:CODE_LO];
  assign cmd_wr    = reg_wr && reg_addr == REG_CMD_PTR;
  assign accept    = cmd_wr && subsystem_ready_flag_q; // RL1
  assign own_now   = msg_own_q || hdr_q[HDR_ACK]; // RL21 RL18
  assign alert_go  = st_q == ST_DECIDE && alert_pend_q && own_now; // RL15
  assign upd_ctl   = st_q == ST_DECIDE && !alert_go; // RL12
  assign dma_state = st_q == ST_HDR || st_q == ST_PARM ||
                     st_q == ST_MSG0 || st_q == ST_MSG1;

  always_comb begin
    dreq = '0;
    case (st_q)
      ST_HDR:  dreq.addr = command_pointer_register_q;
      ST_PARM: dreq.addr = faddr_q;
      ST_MSG0: begin
        dreq.we           = 1'b1;
        dreq.addr         = msg_addr_q;
        dreq.data[3:0]    = kind_q;
        dreq.data[MSG_ACK] = mack_q; // RL5 RL11
      end
      ST_MSG1: begin
        dreq.we   = 1'b1;
        dreq.addr = msg_addr_q + WORD_STEP;
        dreq.data = status_image(subsystem_ready_flag_q, register_write_refused_q,
                                 volume_change_flag_q, interrupt_permit_latch_q,
                                 fail_q, rej_q);
      end
      default: dreq = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ownership and sequencing
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_q                       <= ST_IDLE;
      subsystem_ready_flag_q     <= 1'b1; // RL13
      msg_own_q                  <= 1'b0; // RL13
      keep_q                     <= 1'b0;
      issued_q                   <= 1'b0;
      dma_go_q                   <= 1'b0;
      kind_q                     <= MSG_END;
      mack_q                     <= 1'b0;
      command_pointer_register_q <= '0;
      faddr_q                    <= '0;
      msg_addr_q                 <= '0;
      hdr_q                      <= '0;
      p0_q                       <= '0;
      p1_q                       <= '0;
      left_q                     <= '0;
      pidx_q                     <= PIDX_ZERO;
      xport_start_q              <= 1'b0;
      xport_hdr_q                <= '0;
      xport_parm_q               <= '0;
    end else begin
      dma_go_q      <= 1'b0;
      xport_start_q <= 1'b0;
      if (dma_state && !issued_q) begin
        dma_go_q <= 1'b1;
        issued_q <= 1'b1;
      end else if (dma_done) begin
        issued_q <= 1'b0;
      end
      case (st_q)
        ST_IDLE: begin
          if (accept) begin
            command_pointer_register_q <= ADDR_W'(reg_wdata);
            faddr_q                    <= ADDR_W'(reg_wdata) + WORD_STEP;
            subsystem_ready_flag_q     <= 1'b0; // RL4
            pidx_q                     <= PIDX_ZERO;
            st_q                       <= ST_HDR;
          end else if (alert_pend_q && msg_own_q) begin // RL9 RL17
            subsystem_ready_flag_q <= 1'b0; // RL9
            kind_q                 <= MSG_UNSOLICITED_ALERT;
            mack_q                 <= 1'b0; // RL11
            keep_q                 <= 1'b0; // RL16
            st_q                   <= ST_MSG0;
          end
        end
        ST_HDR: begin
          if (dma_done && dma_err) begin
            kind_q <= MSG_FAIL; // RL19
            mack_q <= 1'b0;
            st_q   <= ST_MSG0;
          end else if (dma_done) begin
            hdr_q  <= dma_rdata;
            left_q <= dma_rdata[LEN_HI:LEN_LO] == LEN_FOUR ? PARMS_LONG : PARMS_SHORT; // RL23
            st_q   <= ST_PARM;
          end
        end
        ST_PARM: begin
          if (dma_done && dma_err) begin
            kind_q <= MSG_FAIL; // RL19
            mack_q <= 1'b0;
            st_q   <= ST_MSG0;
          end else if (dma_done) begin
            if (pidx_q == PIDX_ZERO) begin
              p0_q <= dma_rdata;
            end else if (pidx_q == 2'h1) begin
              p1_q <= dma_rdata; // RL2
            end
            pidx_q  <= pidx_q + 2'h1;
            faddr_q <= faddr_q + WORD_STEP;
            left_q  <= left_q - 2'h1;
            if (left_q == PARMS_SHORT) begin
              st_q <= ST_DECIDE;
            end
          end
        end
        ST_DECIDE: begin
          msg_own_q <= own_now; // RL3 RL18
          if (alert_go) begin
            kind_q <= MSG_UNSOLICITED_ALERT; // RL15
            mack_q <= 1'b0; // RL11
            keep_q <= 1'b0;
            st_q   <= ST_MSG0;
          end else if (!legal_code(code)) begin
            kind_q <= MSG_REJ;
            mack_q <= 1'b1;
            st_q   <= own_now && !keep_q ? ST_MSG0 : ST_FINISH;
          end else begin
            if (code == CODE_SETCHAR) begin
              msg_addr_q <= {p1_q[ADDR_W-DATA_W-1:0], p0_q}; // RL2
            end
            xport_start_q <= 1'b1;
            xport_hdr_q   <= hdr_q;
            xport_parm_q  <= p0_q;
            st_q          <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (xport_done) begin
            if (!msg_own_q || keep_q || code == CODE_RELEASE) begin
              keep_q <= msg_own_q; // RL16 RL7
              st_q   <= ST_FINISH;
            end else begin
              kind_q <= MSG_END;
              mack_q <= 1'b1; // RL5
              st_q   <= ST_MSG0;
            end
          end
        end
        ST_MSG0: begin
          if (dma_done) begin
            st_q <= ST_MSG1;
          end
        end
        ST_MSG1: begin
          if (dma_done) begin
            msg_own_q <= 1'b0; // RL3
            st_q      <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          subsystem_ready_flag_q <= 1'b1; // RL8 RL5
          st_q                   <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alert queue
  always_ff @(posedge clock) begin
    if (!resetn) begin
      alert_pend_q <= 1'b0;
    end else if (unsolicited_alert) begin
      alert_pend_q <= 1'b1;
    end else if (alert_go || (st_q == ST_IDLE && !accept && msg_own_q)) begin
      alert_pend_q <= 1'b0; // RL15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status bits
  always_ff @(posedge clock) begin
    if (!resetn) begin
      register_write_refused_q <= 1'b0;
      volume_change_flag_q     <= ST_VCK_RESET; // RL13
      interrupt_permit_latch_q <= 1'b0;
      fail_q                   <= 1'b0;
      rej_q                    <= 1'b0;
    end else begin
      if (cmd_wr && !subsystem_ready_flag_q) begin
        register_write_refused_q <= 1'b1; // RL10
      end else if (accept) begin
        register_write_refused_q <= 1'b0;
      end
      if (volume_change_in) begin
        volume_change_flag_q <= 1'b1;
      end else if (upd_ctl && hdr_q[HDR_CVC]) begin
        volume_change_flag_q <= 1'b0; // RL12
      end
      if (upd_ctl) begin
        interrupt_permit_latch_q <= hdr_q[FMT_HI:FMT_LO] == FMT_IRQ_ON; // RL22 RL12
      end
      if (dma_done && dma_err && (st_q == ST_HDR || st_q == ST_PARM)) begin
        fail_q <= 1'b1; // RL19
      end else if (accept) begin
        fail_q <= 1'b0;
      end
      if (upd_ctl && !legal_code(code)) begin
        rej_q <= 1'b1;
      end else if (accept) begin
        rej_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read
  always_ff @(posedge clock) begin
    if (!resetn) begin
      reg_rdata_q <= '0;
    end else if (reg_rd && reg_addr == REG_STATUS) begin
      reg_rdata_q <= status_image(subsystem_ready_flag_q, register_write_refused_q,
                                  volume_change_flag_q, interrupt_permit_latch_q,
                                  fail_q, rej_q);
    end else if (reg_rd && reg_addr == REG_CMD_PTR) begin
      reg_rdata_q <= command_pointer_register_q[DATA_W-1:0];
    end else begin
      reg_rdata_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Leaves
  pbo_dma u_dma (
    .clock     (clock),
    .resetn    (resetn),
    .go        (dma_go_q),
    .req       (dreq),
    .done_q    (dma_done),
    .err_q     (dma_err),
    .rdata_q   (dma_rdata),
    .mem_req_q (mem_req),
    .mem_q     (mem_out),
    .mem_gnt   (mem_gnt),
    .mem_err   (mem_err),
    .mem_rdata (mem_rdata)
  );

  pbo_irq u_irq (
    .clock  (clock),
    .resetn (resetn),
    .ready  (subsystem_ready_flag_q),
    .permit (interrupt_permit_latch_q),
    .irq_q  (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence alert_start_s;
    st_q == ST_IDLE && !accept && alert_pend_q && msg_own_q;
  endsequence
  sequence alert_write_s;
    !subsystem_ready_flag_q && st_q == ST_MSG0 ##[1:60] st_q == ST_FINISH;
  endsequence

  ptr_write_a: assert property (accept |=> !subsystem_ready_flag_q && st_q == ST_HDR) // RL4
    else $error("pointer write did not take the command buffer");
  refused_write_a: assert property (cmd_wr && !subsystem_ready_flag_q |=> // RL10
    register_write_refused_q && $stable(command_pointer_register_q))
    else $error("write during busy not refused");
  alert_seq_a: assert property (alert_start_s |=> alert_write_s ##1 // RL9
    subsystem_ready_flag_q)
    else $error("alert sequence broken");
  alert_ack_a: assert property (st_q == ST_MSG0 && kind_q == MSG_UNSOLICITED_ALERT |-> !mack_q) // RL11
    else $error("alert message carries acknowledge");
  lost_cmd_a: assert property (alert_go |=> $stable(interrupt_permit_latch_q) && // RL12
    st_q == ST_MSG0)
    else $error("lost command changed permit");
  reset_own_a: assert property ($rose(resetn) |-> subsystem_ready_flag_q && // RL13
    !msg_own_q && volume_change_flag_q)
    else $error("wrong ownership after initialization");
  fail_msg_a: assert property (dma_done && dma_err && (st_q == ST_HDR || // RL19
    st_q == ST_PARM) |=> st_q == ST_MSG0 && kind_q == MSG_FAIL && fail_q)
    else $error("fetch error without failure message");
  end_ack_a: assert property (st_q == ST_EXEC && xport_done && msg_own_q && !keep_q && // RL5
    code != CODE_RELEASE |=> st_q == ST_MSG0 && mack_q)
    else $error("completion message lacks acknowledge");
  no_msg_a: assert property (st_q == ST_EXEC && xport_done && (!msg_own_q || // RL7
    code == CODE_RELEASE) |=> st_q == ST_FINISH ##1 subsystem_ready_flag_q)
    else $error("message written when none is due");
  set_char_a: assert property (upd_ctl && legal_code(code) && code == CODE_SETCHAR |=> // RL2
    msg_addr_q == {$past(p1_q[ADDR_W-DATA_W-1:0]), $past(p0_q)})
    else $error("message buffer location not taken");
  no_alert_a: assert property (st_q == ST_IDLE && !msg_own_q |=> st_q != ST_MSG0) // RL17
    else $error("alert sent without message buffer");
endmodule // pbo_engine

// ### sim/pbo_mem_model.sv
/*
  Host memory model: one word per granted request, prompt or slow.
  Assumes the engine holds mem_req and mem_out steady until the grant.
*/
`timescale 1ns/1ns
module pbo_mem_model import pbo_pkg::*; (
  // Clock and control
  input  wire logic              clock,
  input  wire logic              slow,
  input  wire logic [ADDR_W-1:0] err_addr,
  // Engine side
  input  wire logic              mem_req,
  input  wire pbo_mreq_t         mem_out,
  output logic                   mem_gnt,
  output logic                   mem_err,
  output logic [DATA_W-1:0]      mem_rdata
);
  logic [DATA_W-1:0] mem [0:255];
  logic [1:0]        wait_q;

  initial begin
    mem_gnt   = 1'b0;
    mem_err   = 1'b0;
    mem_rdata = 16'h0000;
    wait_q    = 2'h0;
  end

  always @(posedge clock) begin
    mem_gnt   <= 1'b0;
    mem_err   <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_gnt) begin
      if (slow && wait_q != 2'h3) begin
        wait_q <= wait_q + 2'h1;
      end else begin
        wait_q  <= 2'h0;
        mem_gnt <= 1'b1;
        mem_err <= mem_out.addr == err_addr;
        if (mem_out.we) begin
          mem[mem_out.addr[8:1]] <= mem_out.data;
        end else begin
          mem_rdata <= mem[mem_out.addr[8:1]];
        end
      end
    end
  end
endmodule // pbo_mem_model

// ### sim/packet_buffer_ownership_tb.sv
/*
  Bench for the packet engine: register tasks, host memory model, transport stub.
  Assumes command packets at 0x0010 and the message buffer at 0x0100.
*/
`timescale 1ns/1ns
module packet_buffer_ownership_tb;
  import pbo_pkg::*;
  logic              clock = 1'b0;
  logic              resetn = 1'b0;
  logic [1:0]        reg_addr = 2'h0;
  logic [15:0]       reg_wdata = 16'h0000;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              alert = 1'b0;
  logic              xport_done = 1'b0;
  logic              slow = 1'b0;
  logic              vol = 1'b0;
  logic [15:0]       xhdr, xparm;
  logic [ADDR_W-1:0] err_addr = 18'h3FFFF;
  logic [15:0]       reg_rdata_q, mem_rdata, st, irq_cnt = 16'h0, xs_cnt = 16'h0, xs0;
  logic              mem_req, mem_gnt, mem_err, xport_start_q, irq;
  pbo_mreq_t         mem_out;
  int                errors = 0;
  int                total_checks = 0;
  int                cycles = 0;

  pbo_engine i_pbo_engine (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .mem_req(mem_req), .mem_out(mem_out), .mem_gnt(mem_gnt), .mem_err(mem_err),
    .mem_rdata(mem_rdata), .unsolicited_alert(alert), .volume_change_in(vol),
    .xport_start_q(xport_start_q), .xport_hdr_q(xhdr), .xport_parm_q(xparm),
    .xport_done(xport_done), .irq(irq));
  pbo_mem_model i_pbo_mem_model (.clock(clock), .slow(slow), .err_addr(err_addr),
    .mem_req(mem_req), .mem_out(mem_out), .mem_gnt(mem_gnt), .mem_err(mem_err),
    .mem_rdata(mem_rdata));

  initial begin
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    xport_done <= xport_start_q;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 16'h1;
    if (xport_start_q === 1'b1) xs_cnt <= xs_cnt + 16'h1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      errors++;
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 st = reg_rdata_q;
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      rd(REG_STATUS);
      n++;
    end while (st[ST_SSR] !== 1'b1 && n < 100);
    chk("ready", {15'h0, st[ST_SSR]}, 16'h0001);
    repeat (3) @(posedge clock);
  endtask
  task automatic cmd(input logic [15:0] h, input logic [15:0] p0);
    i_pbo_mem_model.mem[8] = h;
    i_pbo_mem_model.mem[9] = p0;
    i_pbo_mem_model.mem[10] = 16'h0000;
    i_pbo_mem_model.mem[128] = 16'hFFFF;
    wr(REG_CMD_PTR, 16'h0010);
  endtask
  task automatic ping;
    i_pbo_mem_model.mem[128] = 16'hFFFF;
    @(posedge clock);
    alert <= 1'b1;
    @(posedge clock);
    alert <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    rd(REG_STATUS);
    chk("reset status", st, 16'h0090);
    rd(2'h1);
    chk("unmapped", st, 16'h0000);
    cmd(16'h8084, 16'h0100);
    wr(REG_CMD_PTR, 16'h0010);
    rd(REG_STATUS);
    chk("busy write", st & 16'h1080, 16'h1000);
    wait_rdy();
    chk("setchar msg", i_pbo_mem_model.mem[128], 16'h8000);
    chk("irq on", irq_cnt, 16'h0001);
    chk("xport hdr", xhdr, 16'h8084);
    chk("xport parm", xparm, 16'h0100);
    cmd(16'h000F, 16'h0000);
    wait_rdy();
    chk("no ack msg", i_pbo_mem_model.mem[128], 16'hFFFF);
    chk("irq off", irq_cnt, 16'h0001);
    cmd(16'h8086, 16'h0000);
    wait_rdy();
    chk("reject bits", st & 16'h0820, 16'h0820);
    chk("reject msg", i_pbo_mem_model.mem[128], 16'h8003);
    cmd(16'h808E, 16'h0000);
    wait_rdy();
    chk("release msg", i_pbo_mem_model.mem[128], 16'hFFFF);
    chk("release irq", irq_cnt, 16'h0003);
    ping();
    wait_rdy();
    chk("alert msg", i_pbo_mem_model.mem[128], 16'h0001);
    chk("alert irq", irq_cnt, 16'h0004);
    ping();
    repeat (20) @(posedge clock);
    chk("second alert", i_pbo_mem_model.mem[128], 16'hFFFF);
    ping();
    xs0 = xs_cnt;
    cmd(16'hC00F, 16'h0000);
    wait_rdy();
    chk("queued alert", i_pbo_mem_model.mem[128], 16'h0001);
    chk("lost start", xs_cnt, xs0);
    chk("lost permit", st & 16'h0030, 16'h0030);
    cmd(16'hC00F, 16'h0000);
    wait_rdy();
    chk("reissue start", xs_cnt, xs0 + 16'h1);
    chk("reissue msg", i_pbo_mem_model.mem[128], 16'h8000);
    chk("reissue bits", st & 16'h0030, 16'h0000);
    vol <= 1'b1;
    @(posedge clock);
    vol <= 1'b0;
    rd(REG_STATUS);
    chk("volume set", st & 16'h0010, 16'h0010);
    slow <= 1'b1;
    err_addr <= 18'h00012;
    cmd(16'h8084, 16'h0100);
    wait_rdy();
    chk("fail bit", st & 16'h8000, 16'h8000);
    chk("fail msg", i_pbo_mem_model.mem[128] & 16'h000F, 16'h0002);
    wrap_up();
  end
endmodule // packet_buffer_ownership_tb
